// ### src/bpc_params.svh
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

// ============================================================
// Register port offsets
`define BPC_OFS_CMD     8'h00
`define BPC_OFS_ADDR    8'h04
`define BPC_OFS_DATA    8'h08
`define BPC_OFS_RDATA   8'h0C
`define BPC_OFS_PW0     8'h10
`define BPC_OFS_PW3     8'h1C

// ============================================================
// Status word bit positions
`define BPC_ST_BUSY     0
`define BPC_ST_ERR      1
`define BPC_ST_MODE_LO  2
`define BPC_ST_MODE_HI  3
`define BPC_ST_PWACT    4
`define BPC_ST_VERIFIED 5
`define BPC_ST_BIT0     6

// Lock register bit that selects password mode when written to 0.
`define BPC_PWD_MODE_BIT 2

// ============================================================
// Flash bus widths and codes
`define BPC_AW          26
`define BPC_DW          16
`define BPC_ADR_UNLK1   26'h0000555
`define BPC_ADR_UNLK2   26'h00002AA
`define BPC_ADR_ZERO    26'h0000000
`define BPC_D_UNLK1     16'h00AA
`define BPC_D_UNLK2     16'h0055
`define BPC_D_LOCKSET   16'h0040
`define BPC_D_PWDSET    16'h0060
`define BPC_D_NVPSET    16'h00C0
`define BPC_D_EXIT1     16'h0090
`define BPC_D_ZERO      16'h0000
`define BPC_D_PROG      16'h00A0
`define BPC_D_UNLOCK1   16'h0025
`define BPC_D_UNLOCK2   16'h0003
`define BPC_D_CONFIRM   16'h0029
`define BPC_D_CLR1      16'h0080
`define BPC_D_CLR2      16'h0030
`define BPC_RESET_DATA  16'h0000

// ============================================================
// Bus timing, times in ns at a 10 ns clock
`define BPC_CLK_NS      10
`define BPC_T_WP_NS     50
`define BPC_T_WPH_NS    30
`define BPC_T_ACC_NS    70
`define BPC_WP_CYC      4'((`BPC_T_WP_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_WPH_CYC     4'((`BPC_T_WPH_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_RD_CYC      4'((`BPC_T_ACC_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS + 2)

`endif

// ### src/bpc_pkg.sv
package bpc_pkg;

  typedef enum logic [3:0] {
    BPC_C_NONE       = 4'h0,
    BPC_C_ENTER_LOCK = 4'h1,
    BPC_C_ENTER_PWD  = 4'h2,
    BPC_C_ENTER_NVP  = 4'h3,
    BPC_C_EXIT       = 4'h4,
    BPC_C_PROG_LOCK  = 4'h5,
    BPC_C_READ       = 4'h6,
    BPC_C_PROG_PWD   = 4'h7,
    BPC_C_UNLOCK     = 4'h8,
    BPC_C_PROG_NVP   = 4'h9,
    BPC_C_CLR_NVP    = 4'hA,
    BPC_C_VERIFY     = 4'hB
  } bpc_cmd_t;

  typedef enum logic [1:0] {
    BPC_M_NORMAL = 2'h0,
    BPC_M_LOCK   = 2'h1,
    BPC_M_PWD    = 2'h2,
    BPC_M_NVP    = 2'h3
  } bpc_mode_t;

  typedef enum logic [3:0] {
    BPC_S_IDLE  = 4'b0001,
    BPC_S_WLOW  = 4'b0010,
    BPC_S_WHIGH = 4'b0100,
    BPC_S_RWAIT = 4'b1000
  } bpc_state_t;

  typedef struct packed {
    logic        is_rd;
    logic        last;
    logic [25:0] addr;
    logic [15:0] data;
  } bpc_step_t;

endpackage

// ### src/bpc_host.sv
`timescale 1ns/1ns
`include "bpc_params.svh"
// Functional notes
// - Program and verify password before activation
// - Lock mode entry AA, 55, 40h
// - Password mode entry uses 60h
// - Nonvolatile mode entry uses C0h
// - Exit writes 90h then 00h
// - Unlock: 25h, 03h, password words, 29h
// - Set nonvolatile bit: A0 then 00
// - Clear all nonvolatile: 80h then 30h
// - Every entered mode must be exited
module bpc_host (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // Software register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  // Flash bus
  output logic      [`BPC_AW-1:0]        fl_addr,
  output logic      [`BPC_DW-1:0]        fl_dq_o,
  output logic                           fl_dq_oe,
  input  wire logic [`BPC_DW-1:0]        fl_dq_i,
  output logic                           fl_ce_b,
  output logic                           fl_we_b,
  output logic                           fl_oe_b
);
  import bpc_pkg::*;

  // ============================================================
  // State
  bpc_state_t          state_reg,  state_next;
  bpc_cmd_t            cmd_reg,    cmd_next;
  bpc_mode_t           mode_reg,   mode_next;
  logic [2:0]          idx_reg,    idx_next;
  logic [3:0]          cnt_reg,    cnt_next;
  logic                err_reg,    err_next;
  logic                pwact_reg,  pwact_next;
  logic                ver_reg,    ver_next;
  logic                match_reg,  match_next;
  logic [`BPC_AW-1:0]  baddr_reg,  baddr_next;
  logic [`BPC_DW-1:0]  bdata_reg,  bdata_next;
  logic [`BPC_DW-1:0]  rdat_reg,   rdat_next;
  logic [`BPC_DW-1:0]  pw_reg  [4];
  logic [`BPC_DW-1:0]  pw_next [4];
  logic [`BPC_DW-1:0]  dq_s1_reg, dq_s2_reg;
  logic [`BPC_AW-1:0]  fa_reg,     fa_next;
  logic [`BPC_DW-1:0]  fd_reg,     fd_next;
  logic                foe_reg,    foe_next;
  logic                ce_reg,     ce_next;
  logic                we_reg,     we_next;
  logic                oe_reg,     oe_next;
  logic [31:0]         rd_reg,     rd_next;
  bpc_step_t           stp;
  logic                legal;
  bpc_cmd_t            new_cmd;

  // ============================================================
  // Bus cycle table: one entry per address/data cycle of a command.
  function automatic bpc_step_t step_f(input bpc_cmd_t c, input logic [2:0] i,
                                       input logic [`BPC_AW-1:0] a, input logic [`BPC_DW-1:0] d,
                                       input logic [`BPC_DW-1:0] p0, input logic [`BPC_DW-1:0] p1,
                                       input logic [`BPC_DW-1:0] p2, input logic [`BPC_DW-1:0] p3);
    bpc_step_t s;
    logic [`BPC_DW-1:0] pw_sel;
    s = '{is_rd: 1'b0, last: 1'b0, addr: `BPC_ADR_ZERO, data: `BPC_D_ZERO};
    pw_sel = p0;
    case (a[1:0])
      2'h1:    pw_sel = p1;
      2'h2:    pw_sel = p2;
      2'h3:    pw_sel = p3;
      default: pw_sel = p0;
    endcase
    case (c)
      BPC_C_ENTER_LOCK, BPC_C_ENTER_PWD, BPC_C_ENTER_NVP: begin
        s.addr = (i == 3'd1) ? `BPC_ADR_UNLK2 : `BPC_ADR_UNLK1;
        s.last = (i == 3'd2);
        if (i == 3'd0) s.data = `BPC_D_UNLK1;
        else if (i == 3'd1) s.data = `BPC_D_UNLK2;
        else if (c == BPC_C_ENTER_LOCK) s.data = `BPC_D_LOCKSET;
        else if (c == BPC_C_ENTER_PWD) s.data = `BPC_D_PWDSET;
        else s.data = `BPC_D_NVPSET;
      end
      BPC_C_EXIT: begin
        s.data = (i == 3'd0) ? `BPC_D_EXIT1 : `BPC_D_ZERO;
        s.last = (i == 3'd1);
      end
      BPC_C_PROG_LOCK: begin
        s.data = (i == 3'd0) ? `BPC_D_PROG : d;
        s.last = (i == 3'd1);
      end
      BPC_C_READ: begin
        s.is_rd = 1'b1;
        s.addr  = a;
        s.last  = 1'b1;
      end
      BPC_C_PROG_PWD: begin
        s.data = (i == 3'd0) ? `BPC_D_PROG : pw_sel;
        s.addr = (i == 3'd0) ? `BPC_ADR_ZERO : {24'h000000, a[1:0]};
        s.last = (i == 3'd1);
      end
      BPC_C_UNLOCK: begin
        s.last = (i == 3'd6);
        if (i == 3'd0) s.data = `BPC_D_UNLOCK1;
        else if (i == 3'd1) s.data = `BPC_D_UNLOCK2;
        else if (i == 3'd6) s.data = `BPC_D_CONFIRM;
        else begin
          s.addr = {24'h000000, 2'(i - 3'd2)};
          case (i)
            3'd2:    s.data = p0;
            3'd3:    s.data = p1;
            3'd4:    s.data = p2;
            default: s.data = p3;
          endcase
        end
      end
      BPC_C_PROG_NVP: begin
        s.data = (i == 3'd0) ? `BPC_D_PROG : `BPC_D_ZERO;
        s.addr = (i == 3'd0) ? `BPC_ADR_ZERO : a;
        s.last = (i == 3'd1);
      end
      BPC_C_CLR_NVP: begin
        s.data = (i == 3'd0) ? `BPC_D_CLR1 : `BPC_D_CLR2;
        s.last = (i == 3'd1);
      end
      BPC_C_VERIFY: begin
        s.is_rd = 1'b1;
        s.addr  = {24'h000000, i[1:0]};
        s.last  = (i == 3'd3);
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  // ============================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    mode_next  = mode_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    err_next   = err_reg;
    pwact_next = pwact_reg;
    ver_next   = ver_reg;
    match_next = match_reg;
    baddr_next = baddr_reg;
    bdata_next = bdata_reg;
    rdat_next  = rdat_reg;
    pw_next    = pw_reg;
    fa_next    = fa_reg;
    fd_next    = fd_reg;
    foe_next   = foe_reg;
    ce_next    = ce_reg;
    we_next    = we_reg;
    oe_next    = oe_reg;
    rd_next    = 32'h00000000;
    new_cmd    = bpc_cmd_t'(reg_wdata[3:0]);
    stp = step_f(cmd_reg, idx_reg, baddr_reg, bdata_reg, pw_reg[0], pw_reg[1], pw_reg[2], pw_reg[3]);

    // The host refuses orders its mode rules forbid, so software sees the refusal; a nonvolatile write to a frozen device is not refused.
    case (new_cmd)
      BPC_C_ENTER_LOCK, BPC_C_ENTER_PWD, BPC_C_ENTER_NVP: legal = (mode_reg == BPC_M_NORMAL);
      BPC_C_EXIT:      legal = (mode_reg != BPC_M_NORMAL);
      BPC_C_PROG_LOCK: legal = (mode_reg == BPC_M_LOCK) &&
                               (bdata_reg[`BPC_PWD_MODE_BIT] || (ver_reg && !pwact_reg));
      BPC_C_READ:      legal = !(pwact_reg && mode_reg == BPC_M_PWD);
      BPC_C_PROG_PWD, BPC_C_VERIFY: legal = (mode_reg == BPC_M_PWD) && !pwact_reg;
      BPC_C_UNLOCK:    legal = (mode_reg == BPC_M_PWD);
      BPC_C_PROG_NVP, BPC_C_CLR_NVP: legal = (mode_reg == BPC_M_NVP);
      default:         legal = 1'b0;
    endcase

    if (reg_wr) begin
      case (reg_addr)
        `BPC_OFS_CMD: begin
          if (state_reg == BPC_S_IDLE && legal) begin
            cmd_next   = new_cmd;
            idx_next   = 3'd0;
            err_next   = 1'b0;
            match_next = 1'b1;
            state_next = BPC_S_WLOW;
          end else begin
            err_next = 1'b1;
          end
        end
        `BPC_OFS_ADDR: baddr_next = reg_wdata[`BPC_AW-1:0];
        `BPC_OFS_DATA: bdata_next = reg_wdata[`BPC_DW-1:0];
        default: begin
          if (reg_addr >= `BPC_OFS_PW0 && reg_addr <= `BPC_OFS_PW3 && reg_addr[1:0] == 2'h0) begin
            pw_next[reg_addr[3:2]] = reg_wdata[`BPC_DW-1:0];
            ver_next = 1'b0;
          end
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `BPC_OFS_CMD: begin
          rd_next[`BPC_ST_BUSY]                       = (state_reg != BPC_S_IDLE);
          rd_next[`BPC_ST_ERR]                        = err_reg;
          rd_next[`BPC_ST_MODE_HI:`BPC_ST_MODE_LO]    = mode_reg;
          rd_next[`BPC_ST_PWACT]                      = pwact_reg;
          rd_next[`BPC_ST_VERIFIED]                   = ver_reg;
          rd_next[`BPC_ST_BIT0]                       = rdat_reg[0];
        end
        `BPC_OFS_ADDR:  rd_next = {6'h00, baddr_reg};
        `BPC_OFS_DATA:  rd_next = {16'h0000, bdata_reg};
        `BPC_OFS_RDATA: rd_next = {16'h0000, rdat_reg};
        default: begin
          if (reg_addr >= `BPC_OFS_PW0 && reg_addr <= `BPC_OFS_PW3 && reg_addr[1:0] == 2'h0)
            rd_next = {16'h0000, pw_reg[reg_addr[3:2]]};
        end
      endcase
    end

    case (state_reg)
      BPC_S_IDLE: begin
        ce_next  = 1'b1;
        we_next  = 1'b1;
        oe_next  = 1'b1;
        foe_next = 1'b0;
      end
      BPC_S_WLOW: begin
        ce_next = 1'b0;
        fa_next = stp.addr;
        if (stp.is_rd) begin
          foe_next   = 1'b0;
          oe_next    = 1'b0;
          cnt_next   = `BPC_RD_CYC;
          state_next = BPC_S_RWAIT;
        end else if (we_reg) begin
          fd_next  = stp.data;
          foe_next = 1'b1;
          we_next  = 1'b0;
          cnt_next = `BPC_WP_CYC;
        end else if (cnt_reg > 4'd1) begin
          cnt_next = cnt_reg - 4'd1;
        end else begin
          we_next    = 1'b1;
          cnt_next   = `BPC_WPH_CYC;
          state_next = BPC_S_WHIGH;
        end
      end
      BPC_S_RWAIT: begin
        if (cnt_reg > 4'd1) begin
          cnt_next = cnt_reg - 4'd1;
        end else begin
          oe_next   = 1'b1;
          rdat_next = dq_s2_reg;
          if (cmd_reg == BPC_C_VERIFY) begin
            match_next = match_reg && (dq_s2_reg == pw_reg[idx_reg[1:0]]);
            if (stp.last) ver_next = match_reg && (dq_s2_reg == pw_reg[idx_reg[1:0]]);
          end
          cnt_next   = `BPC_WPH_CYC;
          state_next = BPC_S_WHIGH;
        end
      end
      BPC_S_WHIGH: begin
        if (cnt_reg > 4'd1) begin
          cnt_next = cnt_reg - 4'd1;
        end else if (!stp.last) begin
          idx_next   = idx_reg + 3'd1;
          state_next = BPC_S_WLOW;
        end else begin
          state_next = BPC_S_IDLE;
          foe_next   = 1'b0;
          ce_next    = 1'b1;
          case (cmd_reg)
            BPC_C_ENTER_LOCK: mode_next = BPC_M_LOCK;
            BPC_C_ENTER_PWD:  mode_next = BPC_M_PWD;
            BPC_C_ENTER_NVP:  mode_next = BPC_M_NVP;
            BPC_C_EXIT:       mode_next = BPC_M_NORMAL;
            BPC_C_PROG_LOCK:  if (!bdata_reg[`BPC_PWD_MODE_BIT]) pwact_next = 1'b1;
            BPC_C_PROG_PWD:   ver_next = 1'b0;
            default:          mode_next = mode_reg;
          endcase
        end
      end
      default: state_next = BPC_S_IDLE;
    endcase
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= BPC_S_IDLE;
      cmd_reg   <= BPC_C_NONE;
      mode_reg  <= BPC_M_NORMAL;
      idx_reg   <= 3'd0;
      cnt_reg   <= 4'h0;
      err_reg   <= 1'b0;
      pwact_reg <= 1'b0;
      ver_reg   <= 1'b0;
      match_reg <= 1'b0;
      baddr_reg <= `BPC_ADR_ZERO;
      bdata_reg <= `BPC_RESET_DATA;
      rdat_reg  <= `BPC_RESET_DATA;
      for (int k = 0; k < 4; k++) pw_reg[k] <= `BPC_RESET_DATA;
      dq_s1_reg <= `BPC_RESET_DATA;
      dq_s2_reg <= `BPC_RESET_DATA;
      fa_reg    <= `BPC_ADR_ZERO;
      fd_reg    <= `BPC_D_ZERO;
      foe_reg   <= 1'b0;
      ce_reg    <= 1'b1;
      we_reg    <= 1'b1;
      oe_reg    <= 1'b1;
      rd_reg    <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      mode_reg  <= mode_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      err_reg   <= err_next;
      pwact_reg <= pwact_next;
      ver_reg   <= ver_next;
      match_reg <= match_next;
      baddr_reg <= baddr_next;
      bdata_reg <= bdata_next;
      rdat_reg  <= rdat_next;
      pw_reg    <= pw_next;
      dq_s1_reg <= fl_dq_i;
      dq_s2_reg <= dq_s1_reg;
      fa_reg    <= fa_next;
      fd_reg    <= fd_next;
      foe_reg   <= foe_next;
      ce_reg    <= ce_next;
      we_reg    <= we_next;
      oe_reg    <= oe_next;
      rd_reg    <= rd_next;
    end
  end

  assign reg_rdata = rd_reg;
  assign fl_addr   = fa_reg;
  assign fl_dq_o   = fd_reg;
  assign fl_dq_oe  = foe_reg;
  assign fl_ce_b   = ce_reg;
  assign fl_we_b   = we_reg;
  assign fl_oe_b   = oe_reg;

endmodule // bpc_host

// ### testbench/bpc_host_assertions.sv
`timescale 1ns/1ns
`include "bpc_params.svh"
// ============================================================
// Port checker for the flash protection host.
module bpc_host_assertions (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // Flash bus
  input wire logic [`BPC_AW-1:0] fl_addr,
  input wire logic [`BPC_DW-1:0] fl_dq_o,
  input wire logic               fl_dq_oe,
  input wire logic [`BPC_DW-1:0] fl_dq_i,
  input wire logic               fl_ce_b,
  input wire logic               fl_we_b,
  input wire logic               fl_oe_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ============================================================
  // Strobe timing and idle read data
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_we_len; $fell(fl_we_b) |-> !fl_we_b[*5] ##1 fl_we_b[*3]; endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse length wrong");
  property p_oe_len; $fell(fl_oe_b) |-> !fl_oe_b[*8] ##1 !fl_oe_b ##1 fl_oe_b; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read pulse length wrong");
  property p_we_sel; !fl_we_b |-> !fl_ce_b && fl_dq_oe && fl_oe_b; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write without select or drive");
  property p_hold; $rose(fl_we_b) |-> $stable(fl_addr)[*2]; endproperty
  a_hold: assert property (p_hold) else $error("address moved in write high phase");
  // ============================================================
  // Command cycle order
  property p_unlk; $fell(fl_we_b) && fl_dq_o == 16'h00AA |->
    ##[1:12] ($fell(fl_we_b) && fl_dq_o == 16'h0055 && fl_addr == 26'h00002AA); endproperty
  a_unlk: assert property (p_unlk) else $error("second unlock cycle missing");
  property p_entry; $fell(fl_we_b) && fl_dq_o == 16'h0055 |-> ##[1:12] ($fell(fl_we_b) &&
    fl_addr == 26'h0000555 && fl_dq_o inside {16'h0040, 16'h0060, 16'h00C0}); endproperty
  a_entry: assert property (p_entry) else $error("mode entry cycle wrong");
  property p_exit; $fell(fl_we_b) && fl_dq_o == 16'h0090 |->
    ##[1:12] ($fell(fl_we_b) && fl_dq_o == 16'h0000); endproperty
  a_exit: assert property (p_exit) else $error("exit second cycle missing");
  property p_pwun; $fell(fl_we_b) && fl_dq_o == 16'h0025 |->
    ##[1:12] ($fell(fl_we_b) && fl_dq_o == 16'h0003); endproperty
  a_pwun: assert property (p_pwun) else $error("unlock second cycle missing");
  property p_clr; $fell(fl_we_b) && fl_dq_o == 16'h0080 |->
    ##[1:12] ($fell(fl_we_b) && fl_dq_o == 16'h0030); endproperty
  a_clr: assert property (p_clr) else $error("clear second cycle missing");
endmodule // bpc_host_assertions

bind bpc_host bpc_host_assertions i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr),
  .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_b(fl_ce_b), .fl_we_b(fl_we_b),
  .fl_oe_b(fl_oe_b));

// ### testbench/bpc_flash_model.sv
`timescale 1ns/1ns
// ============================================================
// Behavioural flash: lock register, password and protection bits.
module bpc_flash_model (
  // Clock and power
  input  wire logic        clk_sys,
  input  wire logic        pwr_up,
  input  wire logic        slow,
  // Flash bus
  input  wire logic [25:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_ce_b,
  input  wire logic        fl_we_b,
  input  wire logic        fl_oe_b,
  output logic      [15:0] fl_dq_i
);
  logic [15:0] lock_q = 16'hFFFF;
  logic [15:0] pw [4];
  logic [7:0]  nvp = 8'hFF;
  logic        glock = 1'b1;
  logic [1:0]  mode = 2'd0;
  logic [25:0] pa = '0;
  logic [15:0] pd = '0;
  logic [15:0] rv;
  logic [2:0]  uc = '0;
  logic [2:0]  acc = '0;
  logic        ok = 1'b0;
  always @(posedge fl_we_b) begin
    if (!fl_ce_b) begin
      if (pd == 16'h00A0) begin
        if (mode == 2'd1) lock_q = lock_q & fl_dq_o;
        if (mode == 2'd2 && lock_q[2]) pw[fl_addr[1:0]] = fl_dq_o;
        if (mode == 2'd3 && glock && fl_dq_o == 16'h0) nvp[fl_addr[18:16]] = 1'b0;
      end else if (pd == 16'h0090 && fl_dq_o == 16'h0) mode = 2'd0;
      else if (mode == 2'd0 && pa == 26'h2AA && pd == 16'h0055 && fl_addr == 26'h555) begin
        case (fl_dq_o)
          16'h0040: mode = 2'd1;
          16'h0060: mode = 2'd2;
          16'h00C0: mode = 2'd3;
          default: ;
        endcase
      end else if (mode == 2'd3 && pd == 16'h0080 && fl_dq_o == 16'h0030 && glock) nvp = 8'hFF;
      else if (mode == 2'd2) begin
        if (uc == 3'd0) begin
          ok = 1'b1;
          uc = (fl_dq_o == 16'h0025) ? 3'd1 : 3'd0;
        end else if (uc == 3'd1) uc = (fl_dq_o == 16'h0003) ? 3'd2 : 3'd0;
        else if (uc < 3'd6) begin
          ok = ok && fl_dq_o == pw[fl_addr[1:0]] && fl_addr[1:0] == 2'(uc - 3'd2);
          uc = uc + 3'd1;
        end else begin
          if (fl_dq_o == 16'h0029 && ok) glock = 1'b1;
          uc = 3'd0;
        end
      end
      pa = fl_addr;
      pd = fl_dq_o;
    end
  end
  // In password mode the lock comes back frozen after every power-up.
  always @(posedge pwr_up) begin
    glock = lock_q[2];
    mode = 2'd0;
    uc = 3'd0;
    pd = '0;
  end
  always_ff @(posedge clk_sys) acc <= (fl_ce_b || fl_oe_b) ? 3'd0 : acc + 3'(acc != 3'd7);
  always_comb begin
    case (mode)
      2'd1: rv = lock_q;
      2'd2: rv = lock_q[2] ? pw[fl_addr[1:0]] : 16'hFFFF;
      2'd3: rv = {15'h0, nvp[fl_addr[18:16]]};
      // Outside the command sets a read answers with block status: 1 when the block's nonvolatile bit is programmed, else 0.
      default: rv = {15'h0, ~nvp[fl_addr[18:16]]};
    endcase
  end
  // Data lines show the inverse until access time has passed, so an early sample is caught.
  assign fl_dq_i = (!fl_ce_b && !fl_oe_b && acc >= (slow ? 3'd6 : 3'd1)) ? rv : ~rv;
endmodule // bpc_flash_model

// ### testbench/block_protection_control_tb_top.sv
`timescale 1ns/1ns
`include "bpc_params.svh"
module block_protection_control_tb_top;
  import bpc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        pwr_up = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [25:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic        fl_dq_oe, fl_ce_b, fl_we_b, fl_oe_b;
  logic [15:0] pw [4];
  logic [2:0]  blk;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  bpc_host i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_b(fl_ce_b), .fl_we_b(fl_we_b), .fl_oe_b(fl_oe_b));
  bpc_flash_model i_flash (.clk_sys(clk_sys), .pwr_up(pwr_up), .slow(slow), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_ce_b(fl_ce_b), .fl_we_b(fl_we_b), .fl_oe_b(fl_oe_b), .fl_dq_i(fl_dq_i));
  // ============================================================
  // Register port tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input bpc_cmd_t c, input logic err);
    wr(`BPC_OFS_CMD, {28'h0, c});
    for (int i = 0; i < 200; i++) begin
      rd(`BPC_OFS_CMD, d);
      if (d[`BPC_ST_BUSY] === 1'b0) break;
    end
    chk({30'h0, d[`BPC_ST_BUSY], d[`BPC_ST_ERR]}, {31'h0, err});
  endtask
  task automatic setad(input logic [25:0] a, input logic [15:0] v);
    wr(`BPC_OFS_ADDR, {6'h0, a});
    wr(`BPC_OFS_DATA, {16'h0, v});
  endtask
  function automatic logic [25:0] blkad(input logic [2:0] b);
    return {7'h0, b, 16'h1234};
  endfunction
  task automatic rdnv(input logic [2:0] b, input logic exp);
    setad(blkad(b), 16'h0);
    cmd(BPC_C_READ, 1'b0);
    chk({31'h0, d[`BPC_ST_BIT0]}, {31'h0, exp});
    rd(`BPC_OFS_RDATA, d);
    chk({31'h0, d[0]}, {31'h0, exp});
  endtask
  // A bad load flips one bit of word two only, so the unlock fails late in the sequence.
  task automatic loadpw(input logic bad);
    for (int k = 0; k < 4; k++) wr(8'(`BPC_OFS_PW0 + 4 * k), {16'h0, pw[k] ^ ((bad && k == 2) ? 16'h0100 : 16'h0)});
  endtask
  task automatic chk_mode(input bpc_mode_t m);
    rd(`BPC_OFS_CMD, d);
    chk({30'h0, d[3:2]}, {30'h0, m});
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end
  // ============================================================
  // Main sequence
  initial begin
    d = $urandom(53);
    for (int k = 0; k < 4; k++) pw[k] = 16'h1000 | 16'($urandom() & 32'h0FFF);
    blk = 3'($urandom());
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`BPC_OFS_CMD, d);
    chk(d, 32'h0);
    rd(8'hF0, d);
    chk(d, 32'h0);
    cmd(BPC_C_ENTER_NVP, 1'b0);
    chk_mode(BPC_M_NVP);
    setad(blkad(blk), 16'h0);
    cmd(BPC_C_PROG_NVP, 1'b0);
    rdnv(blk, 1'b0);
    rdnv(blk + 3'd1, 1'b1);
    cmd(BPC_C_CLR_NVP, 1'b0);
    rdnv(blk, 1'b1);
    cmd(BPC_C_EXIT, 1'b0);
    chk_mode(BPC_M_NORMAL);
    cmd(BPC_C_PROG_NVP, 1'b1);
    loadpw(1'b0);
    cmd(BPC_C_ENTER_PWD, 1'b0);
    for (int k = 0; k < 4; k++) begin
      setad(26'(k), pw[k]);
      cmd(BPC_C_PROG_PWD, 1'b0);
    end
    cmd(BPC_C_VERIFY, 1'b0);
    chk({31'h0, d[`BPC_ST_VERIFIED]}, 32'h1);
    cmd(BPC_C_EXIT, 1'b0);
    cmd(BPC_C_ENTER_LOCK, 1'b0);
    setad(26'h0, 16'hFFFB);
    cmd(BPC_C_PROG_LOCK, 1'b0);
    chk({31'h0, d[`BPC_ST_PWACT]}, 32'h1);
    cmd(BPC_C_EXIT, 1'b0);
    cmd(BPC_C_ENTER_PWD, 1'b0);
    cmd(BPC_C_VERIFY, 1'b1);
    cmd(BPC_C_PROG_PWD, 1'b1);
    cmd(BPC_C_READ, 1'b1);
    cmd(BPC_C_EXIT, 1'b0);
    // Power cycle with a slow device from here on.
    slow <= 1'b1;
    rst_b <= 1'b0;
    pwr_up <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    pwr_up <= 1'b0;
    chk({31'h0, i_flash.glock}, 32'h0);
    cmd(BPC_C_ENTER_LOCK, 1'b0);
    setad(26'h0, 16'hFFFB);
    cmd(BPC_C_PROG_LOCK, 1'b1);
    cmd(BPC_C_EXIT, 1'b0);
    cmd(BPC_C_ENTER_NVP, 1'b0);
    setad(blkad(blk), 16'h0);
    cmd(BPC_C_PROG_NVP, 1'b0);
    rdnv(blk, 1'b1);
    cmd(BPC_C_EXIT, 1'b0);
    loadpw(1'b1);
    cmd(BPC_C_ENTER_PWD, 1'b0);
    cmd(BPC_C_UNLOCK, 1'b0);
    chk({31'h0, i_flash.glock}, 32'h0);
    loadpw(1'b0);
    cmd(BPC_C_UNLOCK, 1'b0);
    chk({31'h0, i_flash.glock}, 32'h1);
    cmd(BPC_C_EXIT, 1'b0);
    cmd(BPC_C_ENTER_NVP, 1'b0);
    cmd(BPC_C_PROG_NVP, 1'b0);
    rdnv(blk, 1'b0);
    cmd(BPC_C_EXIT, 1'b0);
    rdnv(blk, 1'b1);
    chk(d, 32'h1);
    rdnv(blk + 3'd1, 1'b0);
    chk(d, 32'h0);
    print_verdict();
  end
endmodule // block_protection_control_tb_top
